// ---- hw/fmo_fault_monitor.sv ----
// fmo_fault_monitor: fault supervision, latched faults, fault outputs for
// the hard-wired and network-mapped paths, lamp blink and current cut.
// assumes: apb master on sys_clk; excitation and clear come from pins;
// overload, deviation and serial events come from logic on sys_clk.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "fmo_defines.svh"

module fmo_fault_monitor
  import fmo_pkg::*;
#(
  parameter int MS_CYCLES = `FMO_MS_US * `FMO_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic excitation_request,
  input wire logic fault_clear_input,
  input wire logic overload_active,
  input wire logic [14:0] position_deviation,
  input wire logic positioning_start,
  input wire logic origin_set,
  input wire logic serial_frame_ok,
  input wire logic serial_error,
  output logic fault_indication_output_direct,
  output logic fault_indication_output_remote,
  output logic fault_lamp,
  output logic motor_current_enable,
  output logic motor_stop,
  output logic deviation_warning,
  output logic irq
);
  localparam int NF = FMO_F_NUM;

  generate
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("fmo_fault_monitor: MS_CYCLES must be at least 2");
    end
  endgenerate

  // pin synchronisers; stage 3 only feeds edge detection
  logic exc_s1, exc_s2, exc_s3, clr_s1, clr_s2, clr_s3;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exc_s1 <= 1'b0;
      exc_s2 <= 1'b0;
      exc_s3 <= 1'b0;
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
      clr_s3 <= 1'b0;
    end else begin
      exc_s1 <= excitation_request;
      exc_s2 <= exc_s1;
      exc_s3 <= exc_s2;
      clr_s1 <= fault_clear_input;
      clr_s2 <= clr_s1;
      clr_s3 <= clr_s2;
    end
  end

  logic clr_fall, exc_rise;
  assign clr_fall = clr_s3 & ~clr_s2;
  assign exc_rise = exc_s2 & ~exc_s3;

  // time bases: milliseconds, tenths of a second, lamp half period
  logic ms_tick, ds_tick, blink_tick;
  fmo_tick #(.LEN(MS_CYCLES)) u_ms (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(1'b1),
    .tick(ms_tick)
  );
  fmo_tick #(.LEN(`FMO_DS_MS)) u_ds (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(ms_tick),
    .tick(ds_tick)
  );
  fmo_tick #(.LEN(`FMO_BLINK_MS)) u_blink (
    .sys_clk(sys_clk),
    .rst(rst),
    .step(ms_tick),
    .tick(blink_tick)
  );

  // ---- configuration registers and apb slave
  logic ctrl_origin, next_ctrl_origin;
  logic [8:0] ovl_lim, next_ovl_lim;
  logic [14:0] devon_lim, next_devon_lim, devoff_lim, next_devoff_lim;
  logic [13:0] tmo_lim, next_tmo_lim;
  logic [3:0] cerr_lim, next_cerr_lim;
  logic [NF-1:0] irq_st, next_irq_st, irq_msk, next_irq_msk;
  logic [NF-1:0] fault, next_fault, ev;
  logic [31:0] next_prdata;
  logic [3:0] cerr_cnt, next_cerr_cnt;
  logic motor_on, dev_warn_now, wr, bad_addr, bad_val;

  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (bad_addr | (pwrite & bad_val));

  always_comb begin
    next_ctrl_origin = ctrl_origin;
    next_ovl_lim = ovl_lim;
    next_devon_lim = devon_lim;
    next_devoff_lim = devoff_lim;
    next_tmo_lim = tmo_lim;
    next_cerr_lim = cerr_lim;
    next_irq_msk = irq_msk;
    next_prdata = prdata;
    bad_addr = 1'b0;
    bad_val = 1'b0;
    // set wins over write-one-to-clear
    next_irq_st = irq_st | ev;
    if (wr && paddr == `FMO_A_IRQST) begin
      next_irq_st = (irq_st & ~pwdata[NF-1:0]) | ev;
    end
    case (paddr)
      `FMO_A_CTRL: if (wr) next_ctrl_origin = pwdata[`FMO_CTRL_ORIGIN];
      `FMO_A_OVL: begin
        bad_val = !fmo_in_range(pwdata, `FMO_SET_MIN, 32'(`FMO_OVL_MAX));
        if (wr && !bad_val) next_ovl_lim = pwdata[8:0];
      end
      `FMO_A_DEVON: begin
        bad_val = !fmo_in_range(pwdata, `FMO_SET_MIN, 32'(`FMO_DEV_MAX));
        if (wr && !bad_val) next_devon_lim = pwdata[14:0];
      end
      `FMO_A_DEVOFF: begin
        bad_val = !fmo_in_range(pwdata, `FMO_SET_MIN, 32'(`FMO_DEV_MAX));
        if (wr && !bad_val) next_devoff_lim = pwdata[14:0];
      end
      `FMO_A_TMO: begin
        // zero is legal here: it switches monitoring off
        bad_val = !fmo_in_range(pwdata, 32'h0, 32'(`FMO_TMO_MAX));
        if (wr && !bad_val) next_tmo_lim = pwdata[13:0];
      end
      `FMO_A_CERR: begin
        bad_val = !fmo_in_range(pwdata, `FMO_SET_MIN, 32'(`FMO_CERR_MAX));
        if (wr && !bad_val) next_cerr_lim = pwdata[3:0];
      end
      `FMO_A_STAT: bad_val = 1'b1;
      `FMO_A_IRQST: bad_val = 1'b0;
      `FMO_A_IRQMSK: if (wr) next_irq_msk = pwdata[NF-1:0];
      default: bad_addr = 1'b1;
    endcase
    // read data is captured in the setup cycle, stable through access
    if (psel && !penable && !pwrite) begin
      next_prdata = '0;
      case (paddr)
        `FMO_A_CTRL: next_prdata[`FMO_CTRL_ORIGIN] = ctrl_origin;
        `FMO_A_OVL: next_prdata[8:0] = ovl_lim;
        `FMO_A_DEVON: next_prdata[14:0] = devon_lim;
        `FMO_A_DEVOFF: next_prdata[14:0] = devoff_lim;
        `FMO_A_TMO: next_prdata[13:0] = tmo_lim;
        `FMO_A_CERR: next_prdata[3:0] = cerr_lim;
        `FMO_A_STAT: begin
          next_prdata[NF-1:0] = fault;
          next_prdata[`FMO_STAT_WARN] = deviation_warning;
          next_prdata[`FMO_STAT_MOTOR] = motor_on;
          next_prdata[`FMO_STAT_CNT_HI:`FMO_STAT_CNT_LO] = cerr_cnt;
        end
        `FMO_A_IRQST: next_prdata[NF-1:0] = irq_st;
        `FMO_A_IRQMSK: next_prdata[NF-1:0] = irq_msk;
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_origin <= 1'b0;
      ovl_lim <= `FMO_OVL_RST;
      devon_lim <= `FMO_DEV_RST_ON;
      devoff_lim <= `FMO_DEV_RST_OFF;
      tmo_lim <= `FMO_TMO_RST;
      cerr_lim <= `FMO_CERR_RST;
      irq_st <= '0;
      irq_msk <= '0;
      prdata <= '0;
    end else begin
      ctrl_origin <= next_ctrl_origin;
      ovl_lim <= next_ovl_lim;
      devon_lim <= next_devon_lim;
      devoff_lim <= next_devoff_lim;
      tmo_lim <= next_tmo_lim;
      cerr_lim <= next_cerr_lim;
      irq_st <= next_irq_st;
      irq_msk <= next_irq_msk;
      prdata <= next_prdata;
    end
  end

  // ---- supervision, fault latch and outputs
  logic [8:0] ovl_cnt, next_ovl_cnt;
  logic [13:0] tmo_cnt, next_tmo_cnt;
  logic fault_any, next_lamp_on;

  assign fault_any = |fault;
  assign motor_on = exc_s2 & ~fault_any;
  assign dev_warn_now = ~motor_on & (position_deviation > devon_lim);

  always_comb begin
    ev = '0;
    // overload time only accumulates while overload persists
    next_ovl_cnt = '0;
    if (overload_active) begin
      next_ovl_cnt = ovl_cnt;
      if (ds_tick && ovl_cnt != `FMO_OVL_MAX) next_ovl_cnt = ovl_cnt + 9'h001;
    end
    ev[FMO_F_OVL] = overload_active && (ovl_cnt >= ovl_lim);
    ev[FMO_F_DEVON] = motor_on && (position_deviation > devon_lim);
    // motor was still off in the cycle before the request edge
    ev[FMO_F_DEVOFF] = exc_rise && !motor_current_enable
                       && (position_deviation > devoff_lim);
    ev[FMO_F_ORIGIN] = ctrl_origin && positioning_start
                       && !origin_set;
    next_tmo_cnt = tmo_cnt;
    if (serial_frame_ok || tmo_lim == '0 || clr_fall) begin
      next_tmo_cnt = '0;
    end else if (ms_tick && tmo_cnt != `FMO_TMO_MAX) begin
      next_tmo_cnt = tmo_cnt + 14'h0001;
    end
    // a count that the clear is zeroing must not relatch its fault
    ev[FMO_F_TMO] = !clr_fall && (tmo_lim != '0)
                    && (tmo_cnt >= tmo_lim);
    next_cerr_cnt = clr_fall ? 4'h0 : cerr_cnt;
    if (serial_error && next_cerr_cnt != `FMO_CERR_MAX) begin
      next_cerr_cnt = next_cerr_cnt + 4'h1;
    end
    ev[FMO_F_CERR] = !clr_fall && (cerr_cnt >= cerr_lim);
    // a new event in the clearing cycle still latches
    next_fault = (fault & {NF{~clr_fall}}) | ev;
    next_lamp_on = fault_any & (fault_lamp ^ blink_tick);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault <= '0;
      ovl_cnt <= '0;
      tmo_cnt <= '0;
      cerr_cnt <= '0;
      fault_lamp <= 1'b0;
      fault_indication_output_direct <= 1'b1;
      fault_indication_output_remote <= 1'b0;
      motor_current_enable <= 1'b0;
      motor_stop <= 1'b0;
      deviation_warning <= 1'b0;
      irq <= 1'b0;
    end else begin
      fault <= next_fault;
      ovl_cnt <= next_ovl_cnt;
      tmo_cnt <= next_tmo_cnt;
      cerr_cnt <= next_cerr_cnt;
      fault_lamp <= next_lamp_on;
      fault_indication_output_direct <= ~fault_any;
      fault_indication_output_remote <= fault_any;
      motor_current_enable <= motor_on;
      motor_stop <= fault_any;
      deviation_warning <= dev_warn_now;
      irq <= |(irq_st & irq_msk);
    end
  end

  // ---- checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_clear_pulse;
    clr_s2 ##1 (!clr_s2 && ev == '0);
  endsequence
  sequence s_fault_held;
    fault_any ##1 fault_any;
  endsequence

  a_direct_open: assert property ((|ev) |-> ##2
    !fault_indication_output_direct)
    else $error("direct fault output still conducting");
  a_paths_opposite: assert property (fault_indication_output_remote
    != fault_indication_output_direct)
    else $error("fault output paths agree");
  a_current_cut: assert property (s_fault_held |->
    !motor_current_enable && motor_stop)
    else $error("motor current not cut on fault");
  a_overload_fault: assert property ((overload_active
    && ovl_cnt >= ovl_lim) |=> fault[FMO_F_OVL])
    else $error("overload fault not raised");
  a_devon_fault: assert property ((motor_on
    && position_deviation > devon_lim) |=> fault[FMO_F_DEVON])
    else $error("current-on deviation fault missed");
  a_dev_warn: assert property ((!motor_on
    && position_deviation > devon_lim) |=> deviation_warning)
    else $error("deviation warning missed");
  a_devoff_fault: assert property ((exc_rise && !motor_current_enable
    && position_deviation > devoff_lim) |=> fault[FMO_F_DEVOFF])
    else $error("current-off deviation fault missed");
  a_origin_off: assert property (!ctrl_origin |->
    !ev[FMO_F_ORIGIN])
    else $error("origin fault while disabled");
  a_tmo_off: assert property ((tmo_lim == '0) |->
    !ev[FMO_F_TMO] ##1 tmo_cnt == '0)
    else $error("timeout monitored while disabled");
  a_cerr_limit: assert property ((!clr_fall && cerr_cnt >= cerr_lim)
    |=> fault[FMO_F_CERR])
    else $error("communication error fault missed");
  a_clear_edge: assert property (s_clear_pulse |=>
    fault == '0)
    else $error("fault not cleared on falling edge");
  a_latch_hold: assert property ((fault_any && !clr_fall)
    |=> $stable(fault) || (fault & $past(fault)) == $past(fault))
    else $error("fault dropped without clear");
  a_excite: assert property ((exc_s2 && !fault_any)
    |=> motor_current_enable)
    else $error("motor not energized");
endmodule

// ---- hw/fmo_defines.svh ----
// fmo_defines.svh: offsets, field positions, reset values, limits and
// timing figures of the fault monitor.
// assumes: included by bare name from fmo_fault_monitor and the testbench.
`ifndef FMO_DEFINES_SVH
`define FMO_DEFINES_SVH

// register byte offsets on the apb slave
`define FMO_A_CTRL 8'h00
`define FMO_A_OVL 8'h04
`define FMO_A_DEVON 8'h08
`define FMO_A_DEVOFF 8'h0C
`define FMO_A_TMO 8'h10
`define FMO_A_CERR 8'h14
`define FMO_A_STAT 8'h18
`define FMO_A_IRQST 8'h1C
`define FMO_A_IRQMSK 8'h20

// ctrl and status field positions
`define FMO_CTRL_ORIGIN 0
`define FMO_STAT_WARN 6
`define FMO_STAT_MOTOR 7
`define FMO_STAT_CNT_LO 8
`define FMO_STAT_CNT_HI 11

// setting ranges and reset values
`define FMO_SET_MIN 32'h0000_0001
`define FMO_OVL_RST 9'h032
`define FMO_OVL_MAX 9'h12C
`define FMO_DEV_RST_ON 15'h012C
`define FMO_DEV_RST_OFF 15'h2710
`define FMO_DEV_MAX 15'h7530
`define FMO_TMO_RST 14'h0000
`define FMO_TMO_MAX 14'h2710
`define FMO_CERR_RST 4'h3
`define FMO_CERR_MAX 4'hA

// timing: clock rate, one millisecond, one tenth second, lamp half period
`define FMO_CLK_MHZ 20
`define FMO_MS_US 1000
`define FMO_DS_MS 100
`define FMO_BLINK_MS 250

`endif

// ---- hw/fmo_pkg.sv ----
// fmo_pkg: types and shared helpers of the fault monitor.
// assumes: compiled before every design module.
package fmo_pkg;

  // one bit per latched fault, in this order
  typedef enum {
    FMO_F_OVL,
    FMO_F_DEVON,
    FMO_F_DEVOFF,
    FMO_F_ORIGIN,
    FMO_F_TMO,
    FMO_F_CERR,
    FMO_F_NUM
  } fmo_fault_t;

  function automatic logic fmo_in_range(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

endpackage

// ---- hw/fmo_tick.sv ----
// fmo_tick: divides a stream of step pulses into one tick every LEN steps.
// assumes: step comes from logic on sys_clk; rst synchronous active high.
`timescale 1ns/10ps
module fmo_tick
  import fmo_pkg::*;
#(
  parameter int LEN = 20000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic step,
  output logic tick
);
  localparam int W = $clog2(LEN);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  generate
    if (LEN < 2) begin : g_bad_len
      $error("fmo_tick: LEN must be at least 2");
    end
  endgenerate

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (step) begin
      if (cnt == W'(LEN - 1)) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ---- sim/fmo_host_model.sv ----
// fmo_host_model: host controller side of the drive's fault pins.
// assumes: same sys_clk as the drive; testbench calls its tasks.
`timescale 1ns/10ps
module fmo_host_model (
  input wire logic sys_clk,
  input wire logic fault_indication_output_direct,
  input wire logic fault_indication_output_remote,
  output logic excitation_request,
  output logic fault_clear_input,
  output logic host_fault_seen
);
  initial begin
    excitation_request = 1'b0;
    fault_clear_input = 1'b0;
  end
  // fault only when direct stops conducting and remote reads one
  assign host_fault_seen = ~fault_indication_output_direct
    & fault_indication_output_remote;
  task automatic excite(input logic v);
    @(posedge sys_clk);
    excitation_request <= v;
  endtask
  // held four cycles so the pin synchroniser cannot miss it
  task automatic clear_pulse();
    @(posedge sys_clk);
    fault_clear_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fault_clear_input <= 1'b0;
  endtask
endmodule

// ---- sim/testbench.sv ----
// testbench: self-checking bench of fmo_fault_monitor and a host model.
// assumes: fmo_pkg compiled first; fmo_defines.svh on the include path.
`timescale 1ns/10ps
`include "fmo_defines.svh"
module testbench;
  import fmo_pkg::*;
  localparam int MS = 20;
  localparam int DS = MS * `FMO_DS_MS;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ovl, pstart, orig, fok, serr, exc, clr, seen;
  logic direct, remote, lamp, cur, stop, warn, irq;
  logic [14:0] dev;
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] rv[6] = '{32'h0, 32'h32, 32'h12C, 32'h2710, 32'h0, 32'h3};
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 91830;
  int thr, k;

  always #25 sys_clk = ~sys_clk;

  fmo_fault_monitor #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .excitation_request(exc), .fault_clear_input(clr),
    .overload_active(ovl), .position_deviation(dev),
    .positioning_start(pstart), .origin_set(orig),
    .serial_frame_ok(fok), .serial_error(serr),
    .fault_indication_output_direct(direct),
    .fault_indication_output_remote(remote), .fault_lamp(lamp),
    .motor_current_enable(cur), .motor_stop(stop),
    .deviation_warning(warn), .irq(irq));

  fmo_host_model host (.sys_clk(sys_clk),
    .fault_indication_output_direct(direct),
    .fault_indication_output_remote(remote), .excitation_request(exc),
    .fault_clear_input(clr), .host_fault_seen(seen));

  function automatic int ovl_lo(input int s);
    return (s - 1) * DS - 10;
  endfunction
  function automatic int ovl_hi(input int s);
    return s * DS + 20;
  endfunction
  function automatic logic sg(input int s);
    case (s)
      0: return remote;
      1: return direct;
      2: return lamp;
      3: return cur;
      4: return warn;
      default: return irq;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      chk("apb_timeout", 1, 0);
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge sys_clk);
      if (sg(s) === v) break;
    end
    if (i == lim) begin
      chk("wait_timeout", s, 32'hFFFF);
      print_verdict();
    end
  endtask
  task automatic pls(input int s);
    @(posedge sys_clk);
    if (s == 0) pstart <= 1'b1;
    else if (s == 1) fok <= 1'b1;
    else serr <= 1'b1;
    @(posedge sys_clk);
    pstart <= 1'b0;
    fok <= 1'b0;
    serr <= 1'b0;
  endtask
  task automatic fault_on(input int b);
    wt(0, 1'b1, 20);
    apb(0, `FMO_A_STAT, 0);
    chk("stat", 32'h1 << b, {26'h0, rd[5:0]});
    chk("direct", 0, direct);
    chk("stop", 1, stop);
    chk("current", 0, cur);
    chk("host_seen", 1, seen);
  endtask
  task automatic clear_all();
    repeat (30) @(negedge sys_clk);
    chk("latched", 1, remote);
    host.clear_pulse();
    wt(1, 1'b1, 20);
    chk("remote", 0, remote);
    apb(0, `FMO_A_STAT, 0);
    chk("stat_clr", 0, {26'h0, rd[5:0]});
  endtask

  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    {ovl, pstart, orig, fok, serr} = 5'h00;
    dev = 15'h0000;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      chk("reset_val", rv[i], rd);
    end
    apb(0, 8'hFC, 0);
    chk("unmapped_err", 1, er);
    chk("idle_direct", 1, direct);
    chk("idle_remote", 0, remote);
    chk("idle_lamp", 0, lamp);
    apb(1, `FMO_A_OVL, 32'h12D);
    chk("ovl_err", 1, er);
    apb(1, `FMO_A_CERR, 32'h0);
    chk("cerr_err", 1, er);
    apb(0, `FMO_A_OVL, 0);
    chk("ovl_keep", 32'h32, rd);
    // error limit drawn at random; fault only on the last error
    thr = 1 + {$random(seed)} % 10;
    apb(1, `FMO_A_CERR, thr);
    apb(1, `FMO_A_IRQST, 32'h3F);
    apb(1, `FMO_A_IRQMSK, 32'h20);
    for (k = 0; k < thr; k++) begin
      pls(2);
      repeat (4) @(negedge sys_clk);
      chk("cerr", k == thr - 1, remote);
    end
    fault_on(5);
    wt(5, 1'b1, 5);
    wt(2, 1'b1, 5100);
    wt(2, 1'b0, 5100);
    clear_all();
    chk("irq_sticky", 1, irq);
    apb(1, `FMO_A_IRQST, 32'h20);
    wt(5, 1'b0, 5);
    apb(1, `FMO_A_OVL, 2);
    @(posedge sys_clk);
    ovl <= 1'b1;
    repeat (ovl_lo(2)) @(negedge sys_clk);
    chk("ovl_early", 0, remote);
    wt(0, 1'b1, ovl_hi(2) - ovl_lo(2));
    fault_on(0);
    @(posedge sys_clk);
    ovl <= 1'b0;
    clear_all();
    // threshold itself passes, one above faults
    thr = 1 + {$random(seed)} % 29999;
    apb(1, `FMO_A_DEVON, thr);
    host.excite(1'b1);
    wt(3, 1'b1, 10);
    @(posedge sys_clk);
    dev <= 15'(thr);
    repeat (6) @(negedge sys_clk);
    chk("dev_equal", 0, remote);
    @(posedge sys_clk);
    dev <= 15'(thr + 1);
    fault_on(1);
    host.excite(1'b0);
    @(posedge sys_clk);
    dev <= 15'h0000;
    clear_all();
    chk("cur_off", 0, cur);
    apb(1, `FMO_A_DEVON, 32'h12C);
    @(posedge sys_clk);
    dev <= 15'h012D;
    wt(4, 1'b1, 6);
    apb(1, `FMO_A_DEVON, 32'h7530);
    wt(4, 1'b0, 6);
    apb(1, `FMO_A_DEVOFF, 32'h1F4);
    @(posedge sys_clk);
    dev <= 15'h0258;
    host.excite(1'b1);
    fault_on(2);
    host.excite(1'b0);
    @(posedge sys_clk);
    dev <= 15'h0000;
    clear_all();
    for (k = 0; k < 2; k++) begin
      apb(1, `FMO_A_CTRL, k);
      pls(0);
      repeat (6) @(negedge sys_clk);
      chk("origin", k, remote);
    end
    fault_on(3);
    clear_all();
    @(posedge sys_clk);
    orig <= 1'b1;
    pls(0);
    repeat (6) @(negedge sys_clk);
    chk("origin_set", 0, remote);
    repeat (100) @(negedge sys_clk);
    chk("tmo_off", 0, remote);
    // frames held on while the setting changes, so no stale count fires
    @(posedge sys_clk);
    fok <= 1'b1;
    apb(1, `FMO_A_TMO, 3);
    @(posedge sys_clk);
    fok <= 1'b0;
    repeat (30) @(negedge sys_clk);
    chk("tmo_early", 0, remote);
    wt(0, 1'b1, 45);
    fault_on(4);
    apb(1, `FMO_A_TMO, 0);
    clear_all();
    print_verdict();
  end
endmodule
